// ===== design/pid_process_controller_consts.svh
// Constants for the process loop controller: field codes, scales, reset values.
// Assumes analog inputs arrive already digitised as unsigned codes.
`ifndef PID_PROCESS_CONTROLLER_CONSTS_SVH
`define PID_PROCESS_CONTROLLER_CONSTS_SVH

`define ADC_WIDTH          12
`define ADC_FULL_SCALE     12'hFFF
`define PCT_WIDTH          14
`define PCT_FULL_SCALE     14'h2710
`define ALARM_WIDTH        10
`define ALARM_FULL_SCALE   10'h3E8
`define UPPER_ALARM_RESET  10'h3E8
`define LOWER_ALARM_RESET  10'h000
`define PBAND_WIDTH        11
`define PBAND_MAX          11'h7D0
`define PBAND_RESET        11'h3E8
`define TARGET_RESET       14'h0000
`define TICK_PERIOD_NS     10000000
`define CLK_PERIOD_NS      100
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define SEG_MASK_WIDTH     16

`define ENABLE_OFF         2'h0
`define ENABLE_ALWAYS      2'h1
`define ENABLE_TERMINAL    2'h2
`define POLARITY_NEGATIVE  1'h0
`define POLARITY_POSITIVE  1'h1
`define SETPOINT_DIGITAL   2'h0
`define SETPOINT_VOLTAGE   2'h1
`define SETPOINT_CURRENT   2'h2
`define FEEDBACK_VOLTAGE   2'h0
`define FEEDBACK_CURRENT   2'h1
`define FEEDBACK_V_MINUS_C 2'h2
`define FEEDBACK_C_MINUS_V 2'h3

`endif

// ===== design/pid_process_controller_pkg.sv
// Types for the process loop controller.
// Assumes the constants header is on the include path.
`include "pid_process_controller_consts.svh"

package pid_process_controller_pkg;

    typedef logic signed [`PCT_WIDTH:0] pct_t;

    typedef enum logic [2:0]
    {
        ST_IDLE    = 3'b001,
        ST_RUN     = 3'b010,
        ST_UPDATE  = 3'b100
    } loop_state_e;

endpackage

// ===== design/pid_process_controller.sv
// Process loop controller: setpoint and feedback selection, alarms,
// proportional-integral frequency correction, segment direction lookup.
// Assumes synchronous inputs and settings held stable by the drive's parameter store.
`timescale 1ns/10ps
`include "pid_process_controller_consts.svh"

module pid_process_controller
    import pid_process_controller_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int FREQ_WIDTH  = 16,
    parameter int INT_SHIFT   = 6
)
(
    input  wire logic                          core_clk_in,
    input  wire logic                          reset_in,
    input  wire logic [1:0]                    loop_enable_select_in,
    input  wire logic                          loop_terminal_in,
    input  wire logic                          loop_polarity_select_in,
    input  wire logic [1:0]                    setpoint_source_select_in,
    input  wire logic [1:0]                    feedback_source_select_in,
    input  wire logic [`PCT_WIDTH-1:0]         digital_target_value_in,
    input  wire logic [`ALARM_WIDTH-1:0]       upper_alarm_limit_in,
    input  wire logic [`ALARM_WIDTH-1:0]       lower_alarm_limit_in,
    input  wire logic [`PBAND_WIDTH-1:0]       proportional_band_in,
    input  wire logic [`ADC_WIDTH-1:0]         voltage_analog_input_in,
    input  wire logic [`ADC_WIDTH-1:0]         current_analog_input_in,
    input  wire logic [`SEG_MASK_WIDTH-1:0]    segment_direction_mask_in,
    input  wire logic [3:0]                    segment_index_in,
    input  wire logic [FREQ_WIDTH-1:0]         base_frequency_in,
    output logic                               segment_reverse_out,
    output logic                               loop_active_out,
    output logic                               upper_alarm_out,
    output logic                               lower_alarm_out,
    output logic                               alarm_out,
    output logic signed [`PCT_WIDTH:0]         error_out,
    output logic [FREQ_WIDTH-1:0]              frequency_out
);

    // Wide enough for the largest error times 1000 over a narrow band plus the base frequency
    localparam int ACC_W     = FREQ_WIDTH + 16;
    localparam int PCT_EXT_W = `PCT_WIDTH + 2;
    localparam logic signed [ACC_W-1:0]     FREQ_SPAN   = ACC_W'({FREQ_WIDTH{1'b1}});
    localparam logic signed [PCT_EXT_W-1:0] PCT_POS_MAX = {2'b00, {`PCT_WIDTH{1'b1}}};
    localparam logic signed [PCT_EXT_W-1:0] PCT_NEG_MIN = {2'b11, {`PCT_WIDTH{1'b0}}};

    typedef struct packed
    {
        loop_state_e                  state;
        logic [23:0]                  tick_cnt;
        logic signed [`PCT_WIDTH:0]   setpoint;
        logic signed [`PCT_WIDTH:0]   feedback;
        logic signed [`PCT_WIDTH:0]   error;
        logic signed [ACC_W-1:0]      integ;
        logic [FREQ_WIDTH-1:0]        freq;
        logic                         reverse;
        logic                         upper;
        logic                         lower;
        logic                         active;
        logic                         alarm;
    } ctrl_s;

    ctrl_s cur_r;
    ctrl_s cur_nxt;

    // Raw code to hundredths of a percent; full scale maps to 100.00 percent
    function automatic pct_t to_pct(input logic [`ADC_WIDTH-1:0] code);
        logic [31:0] p;
        p = (32'(code) * 32'(`PCT_FULL_SCALE)) / 32'(`ADC_FULL_SCALE);
        return pct_t'(p[`PCT_WIDTH:0]);
    endfunction

    // Alarm limit in tenths of a percent to hundredths; settings above full scale
    // are pinned to it, like the digital target
    function automatic pct_t tenth_to_pct(input logic [`ALARM_WIDTH-1:0] v);
        logic [`ALARM_WIDTH-1:0] c;
        if (v > `ALARM_FULL_SCALE)
        begin
            c = `ALARM_FULL_SCALE;
        end
        else
        begin
            c = v;
        end
        return pct_t'({1'b0, c} * 15'h000A);
    endfunction

    // Saturating keeps the sign of a large error; a wrapped sign would drive
    // the correction the wrong way
    function automatic pct_t sat_pct(input logic signed [PCT_EXT_W-1:0] v);
        pct_t r;
        if (v > PCT_POS_MAX)
        begin
            r = pct_t'(PCT_POS_MAX[`PCT_WIDTH:0]);
        end
        else if (v < PCT_NEG_MIN)
        begin
            r = pct_t'(PCT_NEG_MIN[`PCT_WIDTH:0]);
        end
        else
        begin
            r = pct_t'(v[`PCT_WIDTH:0]);
        end
        return r;
    endfunction

    // Integral held within one frequency span each way, so a long-held error
    // cannot wind it up past recovery while the output sits at a clamp
    function automatic logic signed [ACC_W-1:0] hold_integ(input logic signed [ACC_W-1:0] v);
        logic signed [ACC_W-1:0] r;
        if (v > FREQ_SPAN)
        begin
            r = FREQ_SPAN;
        end
        else if (v < -FREQ_SPAN)
        begin
            r = -FREQ_SPAN;
        end
        else
        begin
            r = v;
        end
        return r;
    endfunction

    // Corrected frequency is pinned to the output range rather than wrapped
    function automatic logic [FREQ_WIDTH-1:0] to_freq(input logic signed [ACC_W-1:0] s);
        logic [FREQ_WIDTH-1:0] r;
        if (s < 0)
        begin
            r = '0;
        end
        else if (s > FREQ_SPAN)
        begin
            r = '1;
        end
        else
        begin
            r = s[FREQ_WIDTH-1:0];
        end
        return r;
    endfunction

    pct_t                    v_pct;
    pct_t                    c_pct;
    pct_t                    target_pct;
    logic                    enabled;
    logic signed [ACC_W-1:0] prop;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] err_dir;
    logic [`PBAND_WIDTH-1:0] band;

    always_comb
    begin
        v_pct = to_pct(voltage_analog_input_in);
        c_pct = to_pct(current_analog_input_in);
        // Target beyond full scale is clamped so 100.00 percent stays the ceiling
        if (digital_target_value_in > `PCT_FULL_SCALE)
        begin
            target_pct = pct_t'(`PCT_FULL_SCALE);
        end
        else
        begin
            target_pct = pct_t'(digital_target_value_in);
        end
        case (loop_enable_select_in)
            `ENABLE_OFF:      enabled = 1'b0;
            `ENABLE_ALWAYS:   enabled = 1'b1;
            `ENABLE_TERMINAL: enabled = loop_terminal_in;
            default:          enabled = 1'b0;
        endcase
        // Zero band would divide by zero; treat it as the narrowest legal band
        if (proportional_band_in == '0)
        begin
            band = `PBAND_WIDTH'(1);
        end
        else if (proportional_band_in > `PBAND_MAX)
        begin
            band = `PBAND_MAX;
        end
        else
        begin
            band = proportional_band_in;
        end
    end

    always_comb
    begin
        cur_nxt = cur_r;
        prop    = '0;
        sum     = '0;
        err_dir = '0;

        // Direction follows the selected segment one clock later
        cur_nxt.reverse = segment_direction_mask_in[segment_index_in];

        case (setpoint_source_select_in)
            `SETPOINT_DIGITAL: cur_nxt.setpoint = target_pct;
            `SETPOINT_VOLTAGE: cur_nxt.setpoint = v_pct;
            `SETPOINT_CURRENT: cur_nxt.setpoint = c_pct;
            default:           cur_nxt.setpoint = target_pct;
        endcase

        case (feedback_source_select_in)
            `FEEDBACK_VOLTAGE:   cur_nxt.feedback = v_pct;
            `FEEDBACK_CURRENT:   cur_nxt.feedback = c_pct;
            `FEEDBACK_V_MINUS_C: cur_nxt.feedback = v_pct - c_pct;
            `FEEDBACK_C_MINUS_V: cur_nxt.feedback = c_pct - v_pct;
            default:             cur_nxt.feedback = v_pct;
        endcase

        // Alarms look at last cycle's feedback, so they trail it by one clock
        cur_nxt.upper = (cur_r.feedback > tenth_to_pct(upper_alarm_limit_in));
        cur_nxt.lower = (cur_r.feedback < tenth_to_pct(lower_alarm_limit_in));
        // A negative difference feedback can push the error past its range
        cur_nxt.error = sat_pct(PCT_EXT_W'(cur_r.setpoint) - PCT_EXT_W'(cur_r.feedback));

        case (cur_r.state)
            ST_IDLE:
            begin
                // Idle passes the base frequency through and empties the integral
                cur_nxt.tick_cnt = '0;
                cur_nxt.integ    = '0;
                cur_nxt.freq     = base_frequency_in;
                if (enabled)
                begin
                    cur_nxt.state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                // Losing enable drops straight back to idle, mid interval or not
                if (!enabled)
                begin
                    cur_nxt.state = ST_IDLE;
                end
                else if (cur_r.tick_cnt >= 24'(TICK_CYCLES - 1))
                begin
                    cur_nxt.tick_cnt = '0;
                    cur_nxt.state    = ST_UPDATE;
                end
                else
                begin
                    cur_nxt.tick_cnt = cur_r.tick_cnt + 24'h000001;
                end
            end
            ST_UPDATE:
            begin
                // Error is setpoint minus feedback: positive raises frequency under negative polarity, lowers it under positive
                if (loop_polarity_select_in == `POLARITY_NEGATIVE)
                begin
                    err_dir = ACC_W'(cur_r.error);
                end
                else
                begin
                    err_dir = -ACC_W'(cur_r.error);
                end
                // Gain is 100 percent over band; narrow band means larger step
                prop = (err_dir * ACC_W'(1000)) / $signed(ACC_W'(band));
                cur_nxt.integ = hold_integ(cur_r.integ + (prop >>> INT_SHIFT));
                sum = $signed(ACC_W'(base_frequency_in)) + prop + cur_nxt.integ;
                cur_nxt.freq = to_freq(sum);
                cur_nxt.state = enabled ? ST_RUN : ST_IDLE;
            end
            default:
            begin
                cur_nxt.state = ST_IDLE;
            end
        endcase

        // Status flags leave from flip-flops, in step with the state and alarm bits
        cur_nxt.active = (cur_nxt.state != ST_IDLE);
        cur_nxt.alarm  = cur_nxt.upper | cur_nxt.lower;
    end

    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cur_r <= '{state: ST_IDLE, default: '0};
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    assign segment_reverse_out = cur_r.reverse;
    assign loop_active_out     = cur_r.active;
    assign upper_alarm_out     = cur_r.upper;
    assign lower_alarm_out     = cur_r.lower;
    assign alarm_out           = cur_r.alarm;
    assign error_out           = cur_r.error;
    assign frequency_out       = cur_r.freq;

endmodule // pid_process_controller

// ===== test/pid_loop_checker_sva.sv
// Checker for the process loop controller, bound to its top module.
// Assumes settings are held steady for a few cycles around each check.
`timescale 1ns/10ps
module pid_loop_checker
#(
    parameter int FREQ_WIDTH = 16
)
(
    input wire logic                  core_clk_in,
    input wire logic                  reset_in,
    input wire logic [1:0]            loop_enable_select_in,
    input wire logic                  loop_terminal_in,
    input wire logic [1:0]            feedback_source_select_in,
    input wire logic [9:0]            upper_alarm_limit_in,
    input wire logic [9:0]            lower_alarm_limit_in,
    input wire logic [11:0]           voltage_analog_input_in,
    input wire logic [15:0]           segment_direction_mask_in,
    input wire logic [3:0]            segment_index_in,
    input wire logic [FREQ_WIDTH-1:0] base_frequency_in,
    input wire logic                  segment_reverse_out,
    input wire logic                  loop_active_out,
    input wire logic                  upper_alarm_out,
    input wire logic                  lower_alarm_out,
    input wire logic                  alarm_out,
    input wire logic [FREQ_WIDTH-1:0] frequency_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wire run_on = loop_enable_select_in == 2'h1
        || (loop_enable_select_in == 2'h2 && loop_terminal_in);
    wire v_fb   = feedback_source_select_in == 2'h0;
    // Three steady cycles cover a loop caught in its update cycle
    seg_dir_a: assert property (!$past(reset_in) |-> segment_reverse_out ==
        $past(segment_direction_mask_in[segment_index_in])) else $error("direction bit wrong");
    alarm_or_a: assert property (alarm_out == (upper_alarm_out | lower_alarm_out))
        else $error("alarm not the union");
    loop_off_a: assert property ((!run_on)[*3] |-> !loop_active_out)
        else $error("loop runs while disabled");
    loop_on_a: assert property (run_on[*2] |-> loop_active_out)
        else $error("loop idle while enabled");
    idle_freq_a: assert property ((loop_enable_select_in == 2'h0)[*4]
        |-> frequency_out == $past(base_frequency_in)) else $error("idle frequency wrong");
    upper_hit_a: assert property ((v_fb && voltage_analog_input_in == 12'hFFF
        && upper_alarm_limit_in < 10'h3E8)[*3] |-> upper_alarm_out) else $error("no upper alarm");
    lower_hit_a: assert property ((v_fb && voltage_analog_input_in == 12'h000
        && lower_alarm_limit_in != 10'h000)[*3] |-> lower_alarm_out) else $error("no lower alarm");
    no_alarm_a: assert property ((v_fb && upper_alarm_limit_in == 10'h3E8
        && lower_alarm_limit_in == 10'h000)[*3] |-> !alarm_out) else $error("false alarm");
    cover property (loop_active_out && frequency_out != base_frequency_in);
    cover property ($rose(upper_alarm_out));
    cover property ($rose(lower_alarm_out));
endmodule // pid_loop_checker

bind pid_process_controller pid_loop_checker #(.FREQ_WIDTH(FREQ_WIDTH)) chk (.core_clk_in,
    .reset_in, .loop_enable_select_in, .loop_terminal_in, .feedback_source_select_in,
    .upper_alarm_limit_in, .lower_alarm_limit_in, .voltage_analog_input_in,
    .segment_direction_mask_in, .segment_index_in, .base_frequency_in, .segment_reverse_out,
    .loop_active_out, .upper_alarm_out, .lower_alarm_out, .alarm_out, .frequency_out);

// ===== test/process_transmitter_model.sv
// Process transmitter and enable terminal: present the readings the bench asks for.
// Assumes one clock; readings move at the edge, like a sampled converter.
`timescale 1ns/10ps
module process_transmitter_model
(
    input  wire logic  core_clk_in,
    input  wire logic  [11:0] volt_set_in,
    input  wire logic  [11:0] curr_set_in,
    input  wire logic  term_set_in,
    output logic       [11:0] voltage_out = 12'h000,
    output logic       [11:0] current_out = 12'h000,
    output logic       terminal_out = 1'h0
);
    always @(posedge core_clk_in)
    begin
        voltage_out  <= volt_set_in;
        current_out  <= curr_set_in;
        terminal_out <= term_set_in;
    end
endmodule // process_transmitter_model

// ===== test/testbench.sv
// Self-checking bench for the process loop controller.
// Assumes the transmitter model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %0d seen %0d", nm, e, g); end end
module testbench;
    logic        clk = 0, rst = 1, tset = 0, pol = 0, term, seg_rev, active, up_al, lo_al, al;
    logic [1:0]  en = 2'h0, sp = 2'h0, fb = 2'h0;
    logic [13:0] tgt = 14'h0000;
    logic [9:0]  up = 10'h3E8, lo = 10'h000;
    logic [10:0] band = 11'h3E8;
    logic [11:0] vset = 12'h000, iset = 12'h000, volt, curr;
    logic [15:0] mask = 16'h0000, base = 16'h03E8, freq, f1, f2, f3;
    logic [3:0]  idx = 4'h0;
    logic signed [14:0] err;
    int          errors = 0, n_tests = 0;
    initial forever #50 clk = ~clk;
    process_transmitter_model tx (.core_clk_in(clk), .volt_set_in(vset), .curr_set_in(iset),
        .term_set_in(tset), .voltage_out(volt), .current_out(curr), .terminal_out(term));
    pid_process_controller #(.TICK_CYCLES(4)) dut (.core_clk_in(clk), .reset_in(rst),
        .loop_enable_select_in(en), .loop_terminal_in(term), .loop_polarity_select_in(pol),
        .setpoint_source_select_in(sp), .feedback_source_select_in(fb),
        .digital_target_value_in(tgt), .upper_alarm_limit_in(up), .lower_alarm_limit_in(lo),
        .proportional_band_in(band), .voltage_analog_input_in(volt),
        .current_analog_input_in(curr), .segment_direction_mask_in(mask),
        .segment_index_in(idx), .base_frequency_in(base), .segment_reverse_out(seg_rev),
        .loop_active_out(active), .upper_alarm_out(up_al), .lower_alarm_out(lo_al),
        .alarm_out(al), .error_out(err), .frequency_out(freq));
    task automatic wrap_up;
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic err_row(input logic [1:0] s, f, input logic [11:0] v, c,
                           input logic [13:0] t, input logic signed [14:0] e);
        @(posedge clk);
        sp <= s; fb <= f; vset <= v; iset <= c; tgt <= t;
        settle;
        `CHK("error", e, err)
    endtask
    task automatic alarm_row(input logic [9:0] u, l, input logic [11:0] v, input logic eu, el);
        @(posedge clk);
        fb <= 2'h0; up <= u; lo <= l; vset <= v;
        settle;
        `CHK("upper_alarm", eu, up_al)
        `CHK("lower_alarm", el, lo_al)
        `CHK("alarm", eu | el, al)
    endtask
    // Restarts from idle each time so the integral begins empty
    task automatic loop_run(input logic p, input logic [10:0] b, output logic [15:0] f);
        @(posedge clk);
        en <= 2'h0; pol <= p; band <= b; sp <= 2'h0; fb <= 2'h0; vset <= 12'h000;
        tgt <= 14'h09C4;
        settle;
        @(posedge clk);
        en <= 2'h1;
        for (int n = 0; n < 40 && freq === base; n++)
        begin
            @(posedge clk);
            #1;
        end
        f = freq;
        if (freq === base)
        begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic t_segment;
        for (int k = 0; k < 32; k++)
        begin
            @(posedge clk);
            mask <= k[4] ? 16'hFFF5 : 16'h000A;
            idx <= k[3:0];
            repeat (2) @(posedge clk);
            #1;
            `CHK("segment_reverse", mask[idx], seg_rev)
        end
    endtask
    task automatic t_enable;
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            en <= k[2:1];
            tset <= k[0];
            settle;
            `CHK("loop_active", k[2:1] == 1 || (k[2:1] == 2 && k[0]), active)
        end
    endtask
    task automatic t_error;
        @(posedge clk);
        en <= 2'h0;
        err_row(2'h0, 2'h0, 12'h000, 12'h000, 14'h09C4, 15'h09C4);
        err_row(2'h0, 2'h0, 12'h000, 12'h000, 14'h3FFF, 15'h2710);
        err_row(2'h1, 2'h1, 12'hFFF, 12'h000, 14'h0000, 15'h2710);
        err_row(2'h2, 2'h0, 12'h000, 12'hFFF, 14'h0000, 15'h2710);
        err_row(2'h0, 2'h1, 12'h000, 12'hFFF, 14'h09C4, 15'h62B4);
        err_row(2'h0, 2'h2, 12'hFFF, 12'h000, 14'h09C4, 15'h62B4);
        err_row(2'h0, 2'h3, 12'hFFF, 12'h000, 14'h09C4, 15'h30D4);
        err_row(2'h0, 2'h3, 12'hFFF, 12'h000, 14'h2710, 15'h3FFF);
    endtask
    task automatic t_alarm;
        alarm_row(10'h3E7, 10'h000, 12'hFFF, 1'b1, 1'b0);
        alarm_row(10'h3E8, 10'h000, 12'hFFF, 1'b0, 1'b0);
        alarm_row(10'h3E8, 10'h001, 12'h000, 1'b0, 1'b1);
        alarm_row(10'h3E8, 10'h000, 12'h000, 1'b0, 1'b0);
    endtask
    task automatic t_loop;
        loop_run(1'b0, 11'h3E8, f1);
        `CHK("raise", 1'b1, f1 > base)
        loop_run(1'b0, 11'h1F4, f2);
        `CHK("gain", 1'b1, f2 > f1)
        loop_run(1'b1, 11'h3E8, f3);
        `CHK("lower", 1'b1, f3 < base)
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_segment();
        t_enable();
        t_error();
        t_alarm();
        t_loop();
        wrap_up();
    end
endmodule // testbench
